// *** verilog/mmst_pkg.sv ***
// Shared constants, carriers and states of the management status timing block
package mmst_pkg;

    // Time base
    localparam int CLK_PERIOD_NS  = 40;
    localparam int NS_PER_US      = 1000;
    localparam int NS_PER_MS      = 1_000_000;

    // Initialization deadline, longest time, rounded down
    localparam int INIT_TIME_MS   = 2000;
    localparam int INIT_CYCLES    = INIT_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int INIT_CNT_W     = 32;

    // Minimum reset pulse on the reset pin, least time, rounded up
    localparam int RESET_PULSE_US     = 2;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_CNT_W          = 8;

    // Latched flags, also used for masks and clear-on-read selections
    typedef struct packed {
        logic other;
        logic tx_fault;
        logic rx_los;
        logic init_done;
    } mmst_flag_type;

    localparam mmst_flag_type FLAGS_CLEAR   = 4'h0;
    localparam mmst_flag_type MASK_DEFAULT  = 4'h0;
    localparam mmst_flag_type MASKABLE      = 4'he;
    localparam logic          PDOWN_DEFAULT = 1'b0;

    // Synchroniser bit positions and idle levels
    localparam int SYNC_W   = 7;
    localparam int SY_RST   = 0;
    localparam int SY_SEL   = 1;
    localparam int SY_LP    = 2;
    localparam int SY_SCL   = 3;
    localparam int SY_LOS   = 4;
    localparam int SY_TXF   = 5;
    localparam int SY_OTH   = 6;
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 7'h0b;

    typedef enum {ST_HELD, ST_INIT, ST_RUN} mmst_state_type;

endpackage

// *** verilog/mmst_sync.sv ***
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/10ps
module mmst_sync #(
    parameter int                W       = 1,
    parameter logic [W-1:0]      RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // Pins
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] stage1;

    // Stage one feeds only stage two to keep metastability contained
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            stage1 <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

// *** verilog/mmst_ctrl.sv ***
// Management-plane init, flag, interrupt, select and power sequencing of the module
`timescale 1ns/10ps

// Operation
// - After power-on, insertion or reset release, fully functional within 2000 ms.
// - Reset pin low longer than 2 us is a full reset; host holds it.
// - Answer the serial bus within 2000 ms of power-on.
// - Within 2000 ms clear monitor-not-ready and assert the interrupt.
// - After reset pin rising edge, fully functional within 2000 ms.
// - Low-power pin high enters lower power within 100 us.
// - Any interrupt condition drives the interrupt low within 200 ms.
// - Clear-on-read of a flag releases the interrupt within 500 us.
// - Receive loss sets its flag and interrupt within 100 ms.
// - Transmit fault sets its flag and interrupt within 200 ms.
// - Other conditions set their flag and interrupt within 200 ms.
// - Setting a mask suppresses that flag's interrupt within 100 ms.
// - Clearing a mask resumes that flag's interrupt within 100 ms.
// - Select low: answer serial transactions within 100 us.
// - Select high: stop answering serial transactions within 100 us.
// - Power-down bit set enters lower power within 100 ms.
// - Power-down bit cleared returns to full function within 300 ms.
// - Fully functional shown by interrupt asserted with monitor-not-ready cleared.
// - Clear-on-read deadlines start at falling serial clock after stop.
// - Mask and power-down deadlines start at falling serial clock after stop.
// - Select high ignores serial traffic; select low responds.
// - Completed reset returns writable settings to defaults.
// - Host ignores status until completion interrupt; posted at power-up too.
// - Interrupt output is active low, open drain.
module mmst_ctrl
    import mmst_pkg::*;
#(
    parameter int INIT_CYC = INIT_CYCLES
) (
    // Clock and power-on reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // Host control pins
    input  wire logic          module_reset_low_i,
    input  wire logic          module_select_low_i,
    input  wire logic          low_power_pin_i,
    input  wire logic          scl_i,
    // Monitored conditions
    input  wire logic          rx_los_i,
    input  wire logic          tx_fault_i,
    input  wire logic          other_cond_i,
    // Serial engine events, one-cycle pulses at the stop condition
    input  wire logic          cor_stop_i,
    input  wire mmst_flag_type cor_sel_i,
    input  wire logic          mask_wr_i,
    input  wire mmst_flag_type mask_data_i,
    input  wire logic          pdown_wr_i,
    input  wire logic          pdown_data_i,
    // Status and pins towards the host
    output logic               interrupt_out_low_o,
    output logic               interrupt_oe_low_o,
    output logic               module_present_low_o,
    output logic               serial_enable_o,
    output logic               low_power_o,
    output logic               data_not_ready_o,
    output mmst_flag_type      flags_o
);

    logic [SYNC_W-1:0] pins;
    logic              scl_d;
    logic [2:0]        cond_d;
    logic              rst_s;
    logic              sel_s;
    logic              lp_s;
    logic              scl_fall;
    mmst_state_type    state;
    logic [INIT_CNT_W-1:0] init_cnt;
    logic [LOW_CNT_W-1:0]  low_cnt;
    logic              reset_req;
    logic              init_last;
    logic              init_set;
    mmst_flag_type     set_vec;
    mmst_flag_type     cor_pend;
    mmst_flag_type     mask_pend_val;
    logic              mask_pend;
    mmst_flag_type     mask_eff;
    logic              pdown_pend;
    logic              pdown_pend_val;
    logic              pdown_eff;
    logic              next_int_low;

    mmst_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST_VAL)
    ) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({other_cond_i, tx_fault_i, rx_los_i, scl_i,
                     low_power_pin_i, module_select_low_i, module_reset_low_i}),
        .sync_o    (pins)
    );

    assign rst_s    = pins[SY_RST];
    assign sel_s    = pins[SY_SEL];
    assign lp_s     = pins[SY_LP];
    assign scl_fall = scl_d & ~pins[SY_SCL];

    // Edge history for the serial clock and the monitored conditions
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_d  <= SYNC_RST_VAL[SY_SCL];
            cond_d <= SYNC_RST_VAL[SY_OTH:SY_LOS];
        end else begin
            scl_d  <= pins[SY_SCL];
            cond_d <= pins[SY_OTH:SY_LOS];
        end
    end

    // Reset pin low-time counter; shorter glitches never reach the request
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || rst_s) begin
            low_cnt <= '0;
        end else if (low_cnt != LOW_CNT_W'(RESET_PULSE_CYCLES)) begin
            low_cnt <= low_cnt + LOW_CNT_W'(1);
        end
    end

    assign reset_req = !rst_s && (low_cnt == LOW_CNT_W'(RESET_PULSE_CYCLES - 1));
    assign init_last = (init_cnt == INIT_CNT_W'(INIT_CYC - 1));
    assign init_set  = (state == ST_INIT) && init_last;

    // Init sequencer, timed by the free-running internal clock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state    <= ST_INIT;
            init_cnt <= '0;
        end else if (reset_req) begin
            state    <= ST_HELD;
            init_cnt <= '0;
        end else begin
            case (state)
                ST_HELD: begin
                    init_cnt <= '0;
                    if (rst_s) begin
                        state <= ST_INIT;
                    end
                end
                ST_INIT: begin
                    if (init_last) begin
                        state <= ST_RUN;
                    end else begin
                        init_cnt <= init_cnt + INIT_CNT_W'(1);
                    end
                end
                ST_RUN: begin
                    init_cnt <= '0;
                end
                default: begin
                    state <= ST_INIT;
                end
            endcase
        end
    end

    // New events; conditions are only watched once the module is running
    always_comb begin
        set_vec           = FLAGS_CLEAR;
        set_vec.init_done = init_set;
        set_vec.rx_los    = (state == ST_RUN) && pins[SY_LOS] && !cond_d[0];
        set_vec.tx_fault  = (state == ST_RUN) && pins[SY_TXF] && !cond_d[1];
        set_vec.other     = (state == ST_RUN) && pins[SY_OTH] && !cond_d[2];
    end

    // Clear-on-read waits for the first falling serial clock after the stop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || reset_req) begin
            cor_pend <= FLAGS_CLEAR;
        end else if (cor_stop_i) begin
            cor_pend <= (scl_fall ? FLAGS_CLEAR : cor_pend) | cor_sel_i;
        end else if (scl_fall) begin
            cor_pend <= FLAGS_CLEAR;
        end
    end

    // Latched flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || reset_req) begin
            flags_o <= FLAGS_CLEAR;
        end else begin
            flags_o <= (flags_o & ~(scl_fall ? cor_pend : FLAGS_CLEAR)) | set_vec;
        end
    end

    // Monitor-not-ready status bit
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || reset_req) begin
            data_not_ready_o <= 1'b1;
        end else if (init_set) begin
            data_not_ready_o <= 1'b0;
        end
    end

    // Mask and power-down writes take effect at the falling clock after the stop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || reset_req) begin
            mask_pend     <= 1'b0;
            mask_pend_val <= MASK_DEFAULT;
            mask_eff      <= MASK_DEFAULT;
        end else if (mask_wr_i) begin
            // A fall that meets a new stop belongs to the older write, so land that one first
            if (scl_fall && mask_pend) begin
                mask_eff  <= mask_pend_val;
            end
            mask_pend     <= 1'b1;
            mask_pend_val <= mask_data_i & MASKABLE;
        end else if (scl_fall && mask_pend) begin
            mask_pend     <= 1'b0;
            mask_eff      <= mask_pend_val;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || reset_req) begin
            pdown_pend     <= 1'b0;
            pdown_pend_val <= PDOWN_DEFAULT;
            pdown_eff      <= PDOWN_DEFAULT;
        end else if (pdown_wr_i) begin
            // Same hazard as the mask: the older write still owns this fall
            if (scl_fall && pdown_pend) begin
                pdown_eff  <= pdown_pend_val;
            end
            pdown_pend     <= 1'b1;
            pdown_pend_val <= pdown_data_i;
        end else if (scl_fall && pdown_pend) begin
            pdown_pend     <= 1'b0;
            pdown_eff      <= pdown_pend_val;
        end
    end

    // Unmasked flags pull the open-drain interrupt low
    assign next_int_low = ~|(flags_o & ~mask_eff);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            interrupt_oe_low_o   <= 1'b1;
            interrupt_out_low_o  <= 1'b0;
            module_present_low_o <= 1'b0;
            serial_enable_o      <= 1'b0;
            low_power_o          <= 1'b0;
        end else begin
            interrupt_oe_low_o   <= next_int_low;
            interrupt_out_low_o  <= 1'b0;
            module_present_low_o <= 1'b0;
            // Serial answers are held off until init ends, also after a reset pulse
            serial_enable_o      <= (state == ST_RUN) && !sel_s;
            low_power_o          <= lp_s | pdown_eff;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_ready_flag;
        flags_o.init_done && !data_not_ready_o;
    endsequence

    sequence s_int_driven;
        !interrupt_oe_low_o && !interrupt_out_low_o;
    endsequence

    a_reset_entry: assert property (reset_req |=> state == ST_HELD && data_not_ready_o)
        else $error("reset request did not hold the module");
    a_init_ready: assert property (init_set && !reset_req |=> s_ready_flag ##1 s_int_driven)
        else $error("end of init did not post the ready interrupt");
    a_lp_pin: assert property (lp_s |=> low_power_o)
        else $error("low-power pin did not reduce power");
    a_int_assert: assert property (|(flags_o & ~mask_eff) |=> s_int_driven)
        else $error("unmasked flag did not drive the interrupt");
    a_int_release: assert property (flags_o != FLAGS_CLEAR && !(|(flags_o & ~mask_eff))
                                    |=> interrupt_oe_low_o)
        else $error("interrupt not released with no unmasked flag");
    a_cor_edge: assert property (|($past(flags_o) & ~flags_o)
                                 |-> $past(scl_fall) || $past(reset_req) || $past(sys_rst_i))
        else $error("flag cleared away from a falling serial clock");
    a_los_flag: assert property (set_vec.rx_los && !reset_req
                                 |=> flags_o.rx_los ##1 ($past(mask_eff.rx_los) || !interrupt_oe_low_o))
        else $error("receive loss flag not latched");
    a_txf_flag: assert property (set_vec.tx_fault && !reset_req |=> flags_o.tx_fault)
        else $error("transmit fault flag not latched");
    a_oth_flag: assert property (set_vec.other && !reset_req |=> flags_o.other)
        else $error("other flag not latched");
    a_mask_apply: assert property (scl_fall && mask_pend && !mask_wr_i && !reset_req
                                   |=> mask_eff == $past(mask_pend_val))
        else $error("mask not applied at the falling serial clock");
    a_select_on: assert property (state == ST_RUN && !sel_s && !reset_req |=> serial_enable_o)
        else $error("selected module not answering");
    a_select_off: assert property (sel_s |=> !serial_enable_o)
        else $error("deselected module still answering");
    a_pdown_set: assert property (scl_fall && pdown_pend && pdown_pend_val && !pdown_wr_i && !reset_req
                                  |=> ##1 low_power_o)
        else $error("power-down bit did not reduce power");
    a_defaults: assert property (reset_req |=> mask_eff == MASK_DEFAULT && pdown_eff == PDOWN_DEFAULT)
        else $error("reset left settings away from default");
    a_init_quiet: assert property (state != ST_RUN |=> !serial_enable_o)
        else $error("module answering before init ended");
    a_ready_fall: assert property ($fell(data_not_ready_o) |-> $past(init_set))
        else $error("not-ready bit cleared away from end of init");
    a_pdown_clear: assert property (scl_fall && pdown_pend && !pdown_pend_val
                                    && !pdown_wr_i && !reset_req
                                    |=> ##1 (!low_power_o || $past(lp_s)))
        else $error("power-down clear did not restore full power");

endmodule

// *** sim/mmst_host_model.sv ***
// Host board controller model: serial clock frames and stop events
`timescale 1ns/10ps
module mmst_host_model
    import mmst_pkg::*;
(
    // Clock
    input  wire logic     clk_i,
    // Serial clock and stop events
    output logic          scl_o,
    output logic          cor_stop_o,
    output mmst_flag_type cor_sel_o,
    output logic          mask_wr_o,
    output mmst_flag_type mask_data_o,
    output logic          pdown_wr_o,
    output logic          pdown_data_o
);
    initial begin
        scl_o = 1'b1;
        {cor_stop_o, cor_sel_o, mask_wr_o, mask_data_o, pdown_wr_o, pdown_data_o} = '0;
    end

    // Kind 0 is a clear-on-read, 1 a mask write, 2 a power-down write
    task automatic frame(input int kind, input mmst_flag_type data);
        // Serial clock runs only inside a frame and rests high between frames
        repeat (4) begin
            #160 scl_o = 1'b0;
            #160 scl_o = 1'b1;
        end
        @(posedge clk_i);
        #1;
        cor_stop_o   = (kind == 0);
        mask_wr_o    = (kind == 1);
        pdown_wr_o   = (kind == 2);
        cor_sel_o    = data;
        mask_data_o  = data;
        pdown_data_o = data.init_done;
        @(posedge clk_i);
        #1;
        {cor_stop_o, mask_wr_o, pdown_wr_o} = '0;
        // Qualifiers are stale once the stop pulse has gone, so show garbage
        cor_sel_o    = ~data;
        mask_data_o  = ~data;
        pdown_data_o = ~data.init_done;
        repeat (3) @(posedge clk_i);
        // The falling edge after the stop starts every deadline
        #1 scl_o = 1'b0;
        #160 scl_o = 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
    endtask
endmodule

// *** sim/tb_module_mgmt_status_timing.sv ***
// Self-checking bench for the management status timing block
`timescale 1ns/10ps
module tb_module_mgmt_status_timing;
    import mmst_pkg::*;
    // Short init count keeps the run small
    localparam int INIT_SIM = 200;
    logic          clk, sys_rst, rst_low, sel_low, lp, scl, cor_stop, mask_wr, pdown_wr, pdown_data;
    logic          int_out, int_oe, present, ser_en, lowp, dnr;
    logic [2:0]    cond;
    mmst_flag_type cor_sel, mask_data, flags;
    int            errors      = 0;
    int            checks_done = 0;

    mmst_ctrl #(.INIT_CYC(INIT_SIM)) i_dut (
        .clk_i(clk), .sys_rst_i(sys_rst), .module_reset_low_i(rst_low), .module_select_low_i(sel_low),
        .low_power_pin_i(lp), .scl_i(scl), .rx_los_i(cond[0]), .tx_fault_i(cond[1]), .other_cond_i(cond[2]),
        .cor_stop_i(cor_stop), .cor_sel_i(cor_sel), .mask_wr_i(mask_wr), .mask_data_i(mask_data),
        .pdown_wr_i(pdown_wr), .pdown_data_i(pdown_data), .interrupt_out_low_o(int_out),
        .interrupt_oe_low_o(int_oe), .module_present_low_o(present), .serial_enable_o(ser_en),
        .low_power_o(lowp), .data_not_ready_o(dnr), .flags_o(flags));

    mmst_host_model i_host (
        .clk_i(clk), .scl_o(scl), .cor_stop_o(cor_stop), .cor_sel_o(cor_sel), .mask_wr_o(mask_wr),
        .mask_data_o(mask_data), .pdown_wr_o(pdown_wr), .pdown_data_o(pdown_data));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_flags(input mmst_flag_type got, input mmst_flag_type exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_init;
        chk_bit(dnr, 1'b1, "not ready in init");
        chk_bit(int_oe, 1'b1, "irq idle in init");
        chk_bit(ser_en, 1'b0, "serial off in init");
        cyc(INIT_SIM + 4);
        chk_flags(flags, 4'h1, "init flag");
        chk_bit(dnr, 1'b0, "ready after init");
        chk_bit(int_oe, 1'b0, "completion irq");
        chk_bit(int_out, 1'b0, "open drain level");
        chk_bit(present, 1'b0, "present pin");
        chk_bit(ser_en, 1'b1, "serial on");
        i_host.frame(0, 4'h1);
        chk_flags(flags, 4'h0, "init flag read");
        chk_bit(int_oe, 1'b1, "irq released");
        $display("test init done");
    endtask

    task automatic t_conds;
        mmst_flag_type exp;
        for (int i = 0; i < 3; i++) begin
            exp = mmst_flag_type'(4'h2 << i);
            cond[i] = 1'b1;
            cyc(8);
            chk_flags(flags, exp, "condition flag");
            chk_bit(int_oe, 1'b0, "condition irq");
            // Reading another flag must leave this one alone
            i_host.frame(0, ~exp);
            chk_flags(flags, exp, "unread flag kept");
            i_host.frame(0, exp);
            chk_flags(flags, 4'h0, "flag read");
            chk_bit(int_oe, 1'b1, "irq released");
            cond[i] = 1'b0;
            cyc(4);
        end
        $display("test conditions done");
    endtask

    task automatic t_mask;
        i_host.frame(1, 4'h2);
        cond[0] = 1'b1;
        cyc(8);
        chk_flags(flags, 4'h2, "masked flag latched");
        chk_bit(int_oe, 1'b1, "masked irq");
        i_host.frame(1, 4'h0);
        chk_bit(int_oe, 1'b0, "unmasked irq");
        i_host.frame(0, 4'h2);
        chk_bit(int_oe, 1'b1, "irq released");
        cond[0] = 1'b0;
        $display("test mask done");
    endtask

    task automatic t_select;
        sel_low = 1'b1;
        cyc(5);
        chk_bit(ser_en, 1'b0, "deselected");
        sel_low = 1'b0;
        cyc(5);
        chk_bit(ser_en, 1'b1, "selected");
        $display("test select done");
    endtask

    task automatic t_power;
        lp = 1'b1;
        cyc(5);
        chk_bit(lowp, 1'b1, "low power pin");
        lp = 1'b0;
        cyc(5);
        chk_bit(lowp, 1'b0, "full power pin");
        i_host.frame(2, 4'h1);
        chk_bit(lowp, 1'b1, "power down bit");
        i_host.frame(2, 4'h0);
        chk_bit(lowp, 1'b0, "power down cleared");
        $display("test power done");
    endtask

    task automatic t_reset_pin;
        i_host.frame(2, 4'h1);
        i_host.frame(1, 4'he);
        // Too short a pulse must not reset anything
        rst_low = 1'b0;
        cyc(30);
        rst_low = 1'b1;
        cyc(5);
        chk_bit(dnr, 1'b0, "short pulse ignored");
        chk_bit(lowp, 1'b1, "short pulse keeps power down");
        // Host holds the pin low past the minimum pulse
        rst_low = 1'b0;
        cyc(60);
        chk_bit(dnr, 1'b1, "reset not ready");
        chk_bit(lowp, 1'b0, "power down default");
        chk_bit(ser_en, 1'b0, "serial off in reset");
        rst_low = 1'b1;
        cyc(INIT_SIM + 6);
        chk_flags(flags, 4'h1, "reset init flag");
        chk_bit(int_oe, 1'b0, "reset completion irq");
        i_host.frame(0, 4'h1);
        cond[1] = 1'b1;
        cyc(8);
        chk_bit(int_oe, 1'b0, "mask default after reset");
        i_host.frame(0, 4'h4);
        cond[1] = 1'b0;
        $display("test reset pin done");
    endtask

    task automatic end_sim;
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        rst_low = 1'b1;
        sel_low = 1'b0;
        lp      = 1'b0;
        cond    = 3'h0;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_init();
        t_conds();
        t_mask();
        t_select();
        t_power();
        t_reset_pin();
        end_sim();
    end

    // Whole run needs well under 3000 cycles
    initial begin
        #1_000_000;
        errors++;
        end_sim();
    end
endmodule
